/* sei_host.sv */
// Host model driving the serial command pins of the EEPROM block
`timescale 1ns/100ps
`default_nettype none
module sei_host (
   input  wire logic        clk_i,
   output logic             cs_o,
   output logic             sclk_o,
   output logic             din_o,
   input  wire logic        dout_i,
   input  wire logic        dout_oe_i,
   output logic [15:0]      res_o,
   output logic             res_v_o
);
   int   seed = 5473;
   logic slow = 1'b0;
   // Released output reads as the inverse of the driven level
   wire  line_lvl = dout_oe_i ? dout_i : ~dout_i;

   // Pins idle at time zero, select low
   initial begin
      cs_o    = 1'b0;
      sclk_o  = 1'b0;
      din_o   = 1'b0;
      res_o   = 16'h0000;
      res_v_o = 1'b0;
   end

   // Seeded random source, also used by the bench
   function automatic logic [15:0] rnd();
      return 16'($random(seed));
   endfunction

   // Output seen as a result; data masked while not driven
   function automatic logic [15:0] sv();
      return {14'h0000, dout_oe_i, dout_oe_i & dout_i};
   endfunction

   // Step n core cycles, landing just after an edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // One bit: setup, clock high, clock low, then data goes stale
   task automatic bit_out(input logic b);
      din_o = b;
      tick(8 + (slow ? int'(rnd() & 16'h001f) : 0));
      sclk_o = 1'b1;
      tick(8);
      sclk_o = 1'b0;
      tick(4);
      din_o = ~b;
      tick(1); // Edge passes before the next bit
   endtask

   // Low n bits MSB first, raising select if it is low
   task automatic frame(input logic [39:0] bits, input int n);
      if (!cs_o) begin
         cs_o = 1'b1;
         tick(4);
      end
      for (int i = n - 1; i >= 0; i--) bit_out(bits[i]);
   endtask

   // Select low right after the last bit, then wait
   task automatic drop(input int n);
      cs_o = 1'b0;
      tick(n);
   endtask

   // Hand one result to the bench monitor
   task automatic emit(input logic [15:0] v);
      res_o   = v;
      res_v_o = 1'b1;
      tick(1);
      res_v_o = 1'b0;
   endtask

   // Dummy bit, then n words; data-in is junk meanwhile
   task automatic read_bits(input int n, input logic s);
      logic [15:0] w;
      slow = s;
      emit(sv());
      for (int k = 0; k < n; k++) begin
         for (int j = 0; j < 16; j++) begin
            bit_out(1'(rnd()));
            w = {w[14:0], line_lvl};
         end
         emit(w);
      end
      slow = 1'b0;
   endtask

   // Raise select and sample the status output
   task automatic peek();
      cs_o = 1'b1;
      tick(10);
      emit(sv());
   endtask

   // Busy sample, then wait for ready under a bound
   task automatic status(input int limit);
      int k;
      k = 0;
      peek();
      do begin
         tick(1);
         k++;
      end while (line_lvl !== 1'b1 && k < limit);
      emit(sv());
   endtask
endmodule
`default_nettype wire

/* sei_pkg.sv */
// Constants and types for the serial EEPROM command interface
package sei_pkg;
   localparam int          WORD_W       = 16;
   localparam int          ADDR_W       = 6;
   localparam int          DEPTH        = 64;
   localparam int          CMD_BITS     = 8;
   localparam logic [1:0]  OPC_READ     = 2'h2;
   localparam logic [1:0]  OPC_WRITE    = 2'h1;
   localparam logic [1:0]  OPC_ERASE    = 2'h3;
   localparam logic [1:0]  OPC_EXT      = 2'h0;
   localparam logic [1:0]  EXT_WEN      = 2'h3;
   localparam logic [1:0]  EXT_WR_ALL   = 2'h1;
   localparam logic [1:0]  EXT_DISABLE  = 2'h0;
   localparam logic [1:0]  EXT_ER_ALL   = 2'h2;
   localparam logic [15:0] ERASED_WORD  = 16'hffff;
   localparam logic        DUMMY_BIT    = 1'h0;
   localparam logic        READY_LVL    = 1'h1;
   localparam logic        BUSY_LVL     = 1'h0;
   localparam int          PROG_TIME_MS = 10;
   localparam int          CLK_FREQ_MHZ = 200;
   localparam int          PROG_CYCLES  = PROG_TIME_MS * 1000 * CLK_FREQ_MHZ;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_CMD  = 3'h1,
      ST_READ = 3'h2,
      ST_DATA = 3'h3,
      ST_DONE = 3'h4
   } sei_state_e;

   typedef enum logic [1:0] {
      PK_WORD_WR = 2'h0,
      PK_WORD_ER = 2'h1,
      PK_ALL_WR  = 2'h2,
      PK_ALL_ER  = 2'h3
   } sei_prog_e;
endpackage

/* sei_top.sv */
// Serial EEPROM command decoder, read streamer and program sequencer
`timescale 1ns/100ps
`default_nettype none
module sei_top #(
   parameter int PROG_CYCLES = sei_pkg::PROG_CYCLES
) (
   input  wire logic CORE_CLK_I,
   input  wire logic RESET_N_I,
   input  wire logic CHIP_SELECT_I,
   input  wire logic SERIAL_CLOCK_LINE_I,
   input  wire logic DATA_IN_I,
   output logic      DOUT_O,
   output logic      DOUT_OE_O,
   output logic      BUSY_O,
   output logic      STANDBY_O,
   output logic      WRITE_EN_O
);
   localparam int WW  = sei_pkg::WORD_W;
   localparam int AW  = sei_pkg::ADDR_W;
   localparam int PCW = $clog2(PROG_CYCLES);

   // Programming must outlast the write-all sweep
   if (PROG_CYCLES < sei_pkg::DEPTH + 2) begin : g_chk
      $error("PROG_CYCLES too small for the array sweep");
   end

   // Three-stage pin synchronisers and filtered levels
   logic [2:0] cs_s_ff;
   logic [2:0] sclk_s_ff;
   logic [2:0] di_s_ff;
   logic       cs_lvl_ff;
   logic       sclk_lvl_ff;
   logic       di_lvl_ff;
   wire        cs_lvl_nxt = (cs_s_ff[1] == cs_s_ff[2]) ? cs_s_ff[2] : cs_lvl_ff;
   wire        sclk_lvl_nxt = (sclk_s_ff[1] == sclk_s_ff[2]) ? sclk_s_ff[2] : sclk_lvl_ff;
   wire        di_lvl_nxt = (di_s_ff[1] == di_s_ff[2]) ? di_s_ff[2] : di_lvl_ff;

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         cs_s_ff   <= 3'h0;
         sclk_s_ff <= 3'h0;
         di_s_ff   <= 3'h0;
         cs_lvl_ff <= 1'h0;
         sclk_lvl_ff <= 1'h0;
         di_lvl_ff <= 1'h0;
      end else begin
         cs_s_ff   <= {cs_s_ff[1:0], CHIP_SELECT_I};
         sclk_s_ff <= {sclk_s_ff[1:0], SERIAL_CLOCK_LINE_I};
         di_s_ff   <= {di_s_ff[1:0], DATA_IN_I};
         cs_lvl_ff <= cs_lvl_nxt;
         sclk_lvl_ff <= sclk_lvl_nxt;
         di_lvl_ff <= di_lvl_nxt;
      end
   end

   // Edge events; bits count only on a selected rising clock
   wire sclk_rise = sclk_lvl_nxt & ~sclk_lvl_ff;
   wire cs_fall   = ~cs_lvl_nxt & cs_lvl_ff;
   wire bit_stb   = sclk_rise & cs_lvl_ff;

   // Registers of the command path
   sei_pkg::sei_state_e state_ff;
   sei_pkg::sei_state_e nxt_state;
   sei_pkg::sei_prog_e  pend_kind_ff;
   logic [6:0]          cmd_sr_ff;
   logic [2:0]          cmd_cnt_ff;
   logic [WW-1:0]       data_sr_ff;
   logic [4:0]          data_cnt_ff;
   logic [AW-1:0]       pend_addr_ff;
   logic                pend_ok_ff;
   logic                wel_ff;
   logic                busy_ff;
   logic                stat_ff;

   // Command word as it completes on the eighth bit
   wire [7:0]    cmd_word = {cmd_sr_ff, di_lvl_ff};
   wire [1:0]    cmd_opc  = cmd_word[7:6];
   wire [1:0]    cmd_ext  = cmd_word[5:4];
   wire [AW-1:0] cmd_addr = cmd_word[5:0];
   wire          cmd_done = bit_stb && (state_ff == sei_pkg::ST_CMD)
                            && (cmd_cnt_ff == 3'(sei_pkg::CMD_BITS - 1));

   // Opcode decode
   wire is_ext   = (cmd_opc == sei_pkg::OPC_EXT);
   wire dec_read = cmd_done && (cmd_opc == sei_pkg::OPC_READ);
   wire dec_wr   = cmd_done && (cmd_opc == sei_pkg::OPC_WRITE);
   wire dec_er   = cmd_done && (cmd_opc == sei_pkg::OPC_ERASE);
   wire dec_wen  = cmd_done && is_ext && (cmd_ext == sei_pkg::EXT_WEN);
   wire dec_program_all_words_cmd = cmd_done && is_ext
                                    && (cmd_ext == sei_pkg::EXT_WR_ALL);
   wire dec_disable_programming_cmd = cmd_done && is_ext
                                      && (cmd_ext == sei_pkg::EXT_DISABLE);
   wire dec_erase_all_words_cmd = cmd_done && is_ext
                                  && (cmd_ext == sei_pkg::EXT_ER_ALL);

   // Data phase counts saturate at one word
   wire       data_stb     = bit_stb && (state_ff == sei_pkg::ST_DATA);
   wire [4:0] data_cnt_inc = (data_cnt_ff == 5'(WW)) ? data_cnt_ff : data_cnt_ff + 5'h01;

   // Next state of the command sequencer
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         sei_pkg::ST_IDLE: begin
            if (bit_stb && di_lvl_ff && !busy_ff) begin
               nxt_state = sei_pkg::ST_CMD;
            end
         end
         sei_pkg::ST_CMD: begin
            if (dec_read) begin
               nxt_state = sei_pkg::ST_READ;
            end else if (dec_wr || dec_program_all_words_cmd) begin
               nxt_state = sei_pkg::ST_DATA;
            end else if (cmd_done) begin
               nxt_state = sei_pkg::ST_DONE;
            end
         end
         sei_pkg::ST_READ: nxt_state = sei_pkg::ST_READ;
         sei_pkg::ST_DATA: nxt_state = sei_pkg::ST_DATA;
         sei_pkg::ST_DONE: nxt_state = sei_pkg::ST_DONE;
         default:          nxt_state = sei_pkg::ST_IDLE;
      endcase
      if (cs_fall || !cs_lvl_ff) begin
         nxt_state = sei_pkg::ST_IDLE;
      end
   end

   // Programming engine
   logic [PCW-1:0] prog_cnt_ff;
   logic           mem_we_ff;
   logic [AW-1:0]  mem_wa_ff;
   logic [WW-1:0]  mem_wd_ff;
   logic [AW-1:0]  sweep_left_ff;
   wire            start_prog = cs_fall && pend_ok_ff && !busy_ff;
   wire            prog_end   = busy_ff && (prog_cnt_ff == PCW'(PROG_CYCLES - 1));
   wire            kind_all   = (pend_kind_ff == sei_pkg::PK_ALL_WR)
                                || (pend_kind_ff == sei_pkg::PK_ALL_ER);
   wire            kind_erase = (pend_kind_ff == sei_pkg::PK_WORD_ER)
                                || (pend_kind_ff == sei_pkg::PK_ALL_ER);

   // Shift-in, decode and pending program request
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         state_ff     <= sei_pkg::ST_IDLE;
         cmd_sr_ff    <= 7'h00;
         cmd_cnt_ff   <= 3'h0;
         data_sr_ff   <= 16'h0000;
         data_cnt_ff  <= 5'h00;
         pend_addr_ff <= 6'h00;
         pend_kind_ff <= sei_pkg::PK_WORD_WR;
         pend_ok_ff   <= 1'h0;
         wel_ff       <= 1'h0;
      end else begin
         state_ff <= nxt_state;
         if (state_ff == sei_pkg::ST_IDLE) begin
            cmd_cnt_ff <= 3'h0;
         end else if (bit_stb && state_ff == sei_pkg::ST_CMD) begin
            cmd_sr_ff  <= cmd_word[6:0];
            cmd_cnt_ff <= cmd_cnt_ff + 3'h1;
         end
         if (dec_wen) begin
            wel_ff <= 1'h1;
         end else if (dec_disable_programming_cmd) begin
            wel_ff <= 1'h0;
         end
         if (cmd_done) begin
            pend_addr_ff <= cmd_addr;
            data_cnt_ff  <= 5'h00;
            pend_ok_ff   <= (dec_er || dec_erase_all_words_cmd) && wel_ff;
            if (dec_wr) begin
               pend_kind_ff <= sei_pkg::PK_WORD_WR;
            end else if (dec_er) begin
               pend_kind_ff <= sei_pkg::PK_WORD_ER;
            end else if (dec_program_all_words_cmd) begin
               pend_kind_ff <= sei_pkg::PK_ALL_WR;
            end else begin
               pend_kind_ff <= sei_pkg::PK_ALL_ER;
            end
         end else if (data_stb) begin
            data_sr_ff  <= {data_sr_ff[WW-2:0], di_lvl_ff};
            data_cnt_ff <= data_cnt_inc;
            pend_ok_ff  <= wel_ff && (data_cnt_inc == 5'(WW));
         end else if (cs_fall) begin
            pend_ok_ff <= 1'h0;
         end
      end
   end

   // Self-timed cycle: one write per core cycle, then wait out the timer
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         busy_ff       <= 1'h0;
         prog_cnt_ff   <= '0;
         mem_we_ff     <= 1'h0;
         mem_wa_ff     <= 6'h00;
         mem_wd_ff     <= 16'h0000;
         sweep_left_ff <= 6'h00;
      end else begin
         if (start_prog) begin
            busy_ff       <= 1'h1;
            prog_cnt_ff   <= '0;
            mem_we_ff     <= 1'h1;
            mem_wa_ff     <= kind_all ? 6'h00 : pend_addr_ff;
            mem_wd_ff     <= kind_erase ? sei_pkg::ERASED_WORD : data_sr_ff;
            sweep_left_ff <= kind_all ? 6'(sei_pkg::DEPTH - 1) : 6'h00;
         end else begin
            if (busy_ff) begin
               prog_cnt_ff <= prog_cnt_ff + PCW'(1);
            end
            if (prog_end) begin
               busy_ff <= 1'h0;
            end
            if (mem_we_ff && sweep_left_ff != 6'h00) begin
               mem_wa_ff     <= mem_wa_ff + 6'h01;
               sweep_left_ff <= sweep_left_ff - 6'h01;
            end else begin
               mem_we_ff <= 1'h0;
            end
         end
      end
   end

   // Status flag: a new cycle beats any clear in the same clock
   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         stat_ff <= 1'h0;
      end else if (start_prog) begin
         stat_ff <= 1'h1;
      end else if (prog_end && !cs_lvl_ff) begin
         stat_ff <= 1'h0;
      end else if (bit_stb && di_lvl_ff) begin
         stat_ff <= 1'h0;
      end else if (cs_fall && !busy_ff) begin
         stat_ff <= 1'h0;
      end
   end

   // Read streamer
   logic [WW-1:0] rd_sr_ff;
   logic [3:0]    rd_cnt_ff;
   logic [AW-1:0] rd_addr_ff;
   logic          rd_req_ff;
   logic          rd_load_ff;
   logic          rd_bit_ff;
   logic [WW-1:0] mem_q;
   wire           rd_stb  = bit_stb && (state_ff == sei_pkg::ST_READ);
   wire           rd_last = rd_stb && (rd_cnt_ff == 4'hf);

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         rd_sr_ff   <= 16'h0000;
         rd_cnt_ff  <= 4'h0;
         rd_addr_ff <= 6'h00;
         rd_req_ff  <= 1'h0;
         rd_load_ff <= 1'h0;
         rd_bit_ff  <= 1'h0;
      end else begin
         rd_req_ff  <= dec_read || rd_last;
         rd_load_ff <= rd_req_ff;
         if (dec_read) begin
            rd_addr_ff <= cmd_addr;
            rd_bit_ff  <= sei_pkg::DUMMY_BIT;
         end else if (rd_stb) begin
            rd_bit_ff <= rd_sr_ff[WW-1];
            rd_sr_ff  <= {rd_sr_ff[WW-2:0], 1'h0};
            rd_cnt_ff <= rd_cnt_ff + 4'h1;
            if (rd_last) begin
               rd_addr_ff <= rd_addr_ff + 6'h01;
            end
         end
         if (rd_load_ff) begin
            rd_sr_ff  <= mem_q;
            rd_cnt_ff <= 4'h0;
         end
      end
   end

   // Word array
   sei_word_mem #(
      .WORD_W (WW),
      .ADDR_W (AW)
   ) u_mem (
      .clk_i   (CORE_CLK_I),
      .we_i    (mem_we_ff),
      .waddr_i (mem_wa_ff),
      .wdata_i (mem_wd_ff),
      .re_i    (rd_req_ff),
      .raddr_i (rd_addr_ff),
      .rdata_o (mem_q)
   );

   // Output selection: read data, else status, else released
   wire show_rd   = (state_ff == sei_pkg::ST_READ) && cs_lvl_ff;
   wire show_stat = stat_ff && cs_lvl_ff && !show_rd;
   wire nxt_oe    = show_rd || show_stat;
   wire nxt_dout  = show_rd ? rd_bit_ff
                  : show_stat ? (busy_ff ? sei_pkg::BUSY_LVL : sei_pkg::READY_LVL) : 1'h0;

   always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         DOUT_O     <= 1'h0;
         DOUT_OE_O  <= 1'h0;
         BUSY_O     <= 1'h0;
         STANDBY_O  <= 1'h0;
         WRITE_EN_O <= 1'h0;
      end else begin
         DOUT_O     <= nxt_dout;
         DOUT_OE_O  <= nxt_oe;
         BUSY_O     <= busy_ff;
         STANDBY_O  <= !cs_lvl_ff && !busy_ff;
         WRITE_EN_O <= wel_ff;
      end
   end

   // Checks
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (!RESET_N_I);

   a_standby_entry: assert property ((!cs_lvl_ff && !busy_ff) |=> STANDBY_O)
      else $error("standby not entered with select low and idle");
   a_read_dummy: assert property (dec_read |=> (rd_bit_ff == 1'h0) ##1 DOUT_O == 1'h0)
      else $error("read did not lead with a zero bit");
   a_dout_edge: assert property ($changed(rd_bit_ff) |-> $past(rd_stb || dec_read))
      else $error("read output moved without a rising clock");
   a_addr_wrap: assert property (rd_last |=> rd_addr_ff == $past(rd_addr_ff) + 6'h01)
      else $error("read address did not advance after a word");
   a_wel_set: assert property ($rose(wel_ff) |-> $past(dec_wen))
      else $error("enable latch set without enable command");
   a_prog_gate: assert property (start_prog |-> wel_ff)
      else $error("programming started while write disabled");
   a_prog_start: assert property (start_prog |=> busy_ff && mem_we_ff)
      else $error("programming did not start on select fall");
   a_busy_shown: assert property ((stat_ff && cs_lvl_ff && busy_ff && !show_rd)
                                  |=> DOUT_OE_O && !DOUT_O)
      else $error("busy not shown low on output");
   a_no_late_stat: assert property ((prog_end && !cs_lvl_ff) |=> !stat_ff)
      else $error("status kept after cycle ended with select low");
   a_stat_clear: assert property ((bit_stb && di_lvl_ff && !start_prog) |=> !stat_ff)
      else $error("status not cleared by clock with data high");
   a_wdis_clear: assert property (dec_disable_programming_cmd |=> !wel_ff)
      else $error("disable command left latch set");
   a_erase_ones: assert property ((start_prog && kind_erase)
                                  |=> mem_wd_ff == sei_pkg::ERASED_WORD)
      else $error("erase did not write all ones");
   a_all_sweep: assert property ((start_prog && kind_all) |=> sweep_left_ff == 6'h3f)
      else $error("write-all sweep not armed for every word");

   c_read: cover property (rd_last ##1 rd_load_ff);
   c_prog_all: cover property (start_prog && kind_all);
   c_ready_shown: cover property (DOUT_OE_O && DOUT_O && stat_ff && !busy_ff);
endmodule
`default_nettype wire

/* sei_top_bench.sv */
// Self-checking bench for the serial EEPROM command interface
`timescale 1ns/100ps
`default_nettype none
module sei_top_bench;
   localparam int PROG = 200;
   logic        core_clk = 1'b0;
   logic        reset_n  = 1'b0;
   logic        cs, sclk, din, res_v;
   logic [15:0] res;
   logic        dout, dout_oe, busy, standby, write_en;
   int          miscompares = 0;
   int          tests_run   = 0;
   int          cycles      = 0;
   int          gap         = 0;
   logic [15:0] exp_q [$];
   logic [15:0] mem_m [64];
   logic [15:0] pat, r1, r2;

   sei_top #(.PROG_CYCLES(PROG)) u_dut (
      .CORE_CLK_I         (core_clk),
      .RESET_N_I          (reset_n),
      .CHIP_SELECT_I      (cs),
      .SERIAL_CLOCK_LINE_I(sclk),
      .DATA_IN_I          (din),
      .DOUT_O             (dout),
      .DOUT_OE_O          (dout_oe),
      .BUSY_O             (busy),
      .STANDBY_O          (standby),
      .WRITE_EN_O         (write_en)
   );

   sei_host u_host (
      .clk_i    (core_clk),
      .cs_o     (cs),
      .sclk_o   (sclk),
      .din_o    (din),
      .dout_i   (dout),
      .dout_oe_i(dout_oe),
      .res_o    (res),
      .res_v_o  (res_v)
   );

   // 200 MHz core clock
   always #2.5 core_clk = ~core_clk;

   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Counts and verdict, then stop
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Each result from the host is matched to the oldest note
   always @(posedge core_clk) begin
      if (res_v === 1'b1) begin
         if (exp_q.size() == 0) check(res, 16'hdead);
         else check(res, exp_q.pop_front());
      end
   end

   // Cycle ceiling against a hang
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         final_report();
      end
   end

   // Frame images: start bit, opcode, address, optional data
   function automatic logic [39:0] c9(input logic [1:0] op, input logic [5:0] a);
      return 40'({1'b1, op, a});
   endfunction
   function automatic logic [39:0] fr(input logic [1:0] op, input logic [5:0] a,
                                      input logic [15:0] d);
      return 40'({1'b1, op, a, d});
   endfunction

   // Random spacing: select low, or idle, for n plus a few cycles
   task automatic end_frame(input int n);
      gap = n + int'(u_host.rnd() & 16'h000f);
      u_host.drop(gap);
   endtask
   task automatic idle_wait(input int n);
      gap = n + int'(u_host.rnd() & 16'h000f);
      u_host.tick(gap);
   endtask

   // Opcode 00 command without data, then select low
   task automatic cmd(input logic [1:0] top, input logic [3:0] rest);
      u_host.frame(c9(sei_pkg::OPC_EXT, {top, rest}), 9);
      end_frame(60);
   endtask

   // Frame, close, check busy; status 1 drops select, 2 keeps it
   task automatic prog(input logic [39:0] b, input int n, input logic on,
                       input int st);
      u_host.frame(b, n);
      check(16'(dout_oe), 16'h0000);
      end_frame(10);
      check(16'(busy), 16'(on));
      check(16'(standby), 16'(!on));
      idle_wait(50);
      if (st > 0) begin
         exp_q.push_back(16'h0002);
         exp_q.push_back(16'h0003);
         u_host.status(PROG + 200);
         if (st == 1) end_frame(60);
      end
   endtask

   // Read n words from a; nb is 8 when the start bit went earlier
   task automatic read_at(input logic [5:0] a, input int n, input logic s,
                          input int nb);
      exp_q.push_back(16'h0002);
      for (int i = 0; i < n; i++) exp_q.push_back(mem_m[6'(a + i)]);
      u_host.frame(c9(sei_pkg::OPC_READ, a), nb);
      u_host.read_bits(n, s);
      end_frame(60);
   endtask

   // Main sequence
   initial begin
      repeat (16) @(posedge core_clk);
      #1;
      reset_n = 1'b1;
      idle_wait(10);
      check(16'(write_en), 16'h0000);
      check(16'(standby), 16'h0001);
      $display("Test reset done");
      prog(fr(sei_pkg::OPC_WRITE, 6'h05, 16'h1234), 25, 1'b0, 0);
      cmd(sei_pkg::EXT_WEN, 4'h5);
      check(16'(write_en), 16'h0001);
      $display("Test enable done");
      // Whole-array write with extra data bits, then word operations
      pat = u_host.rnd();
      prog(40'({1'b1, sei_pkg::OPC_EXT, sei_pkg::EXT_WR_ALL, 8'h3c, pat}), 29, 1'b1, 1);
      foreach (mem_m[i]) mem_m[i] = pat;
      prog(c9(sei_pkg::OPC_ERASE, 6'h01), 9, 1'b1, 1);
      mem_m[1] = sei_pkg::ERASED_WORD;
      r1 = u_host.rnd();
      prog(fr(sei_pkg::OPC_WRITE, 6'h3f, r1), 25, 1'b1, 1);
      mem_m[63] = r1;
      r1 = u_host.rnd();
      prog(fr(sei_pkg::OPC_WRITE, 6'h00, r1), 25, 1'b1, 2);
      mem_m[0] = r1;
      // Start bit during status ends it and opens a read
      u_host.frame(40'h1, 1);
      check(16'(dout_oe), 16'h0000);
      read_at(6'h3e, 4, 1'b1, 8);
      $display("Test word ops and wrap done");
      // Select raised only after the cycle shows no status
      r2 = u_host.rnd();
      prog(fr(sei_pkg::OPC_WRITE, 6'h02, r2), 25, 1'b1, 0);
      mem_m[2] = r2;
      idle_wait(PROG + 200);
      check(16'(standby), 16'h0001);
      exp_q.push_back(16'h0000);
      u_host.peek();
      end_frame(60);
      $display("Test late select done");
      // Disable blocks programming
      cmd(sei_pkg::EXT_DISABLE, 4'h9);
      check(16'(write_en), 16'h0000);
      prog(c9(sei_pkg::OPC_EXT, {sei_pkg::EXT_ER_ALL, 4'h0}), 9, 1'b0, 0);
      read_at(6'h00, 3, 1'b0, 9);
      $display("Test disable done");
      // Erase-all after a fresh enable
      cmd(sei_pkg::EXT_WEN, 4'h0);
      prog(c9(sei_pkg::OPC_EXT, {sei_pkg::EXT_ER_ALL, 4'h6}), 9, 1'b1, 1);
      foreach (mem_m[i]) mem_m[i] = sei_pkg::ERASED_WORD;
      read_at(6'h3f, 2, 1'b1, 9);
      $display("Test erase all done");
      check(16'(exp_q.size()), 16'h0000);
      final_report();
   end
endmodule
`default_nettype wire

/* sei_word_mem.sv */
// Word array with one write port and a registered read port
`timescale 1ns/100ps
`default_nettype none
module sei_word_mem #(
   parameter int WORD_W = 16,
   parameter int ADDR_W = 6
) (
   input  wire logic              clk_i,
   input  wire logic              we_i,
   input  wire logic [ADDR_W-1:0] waddr_i,
   input  wire logic [WORD_W-1:0] wdata_i,
   input  wire logic              re_i,
   input  wire logic [ADDR_W-1:0] raddr_i,
   output logic      [WORD_W-1:0] rdata_o
);
   logic [WORD_W-1:0] mem_ff [0:(1<<ADDR_W)-1];

   // Refuse shapes the array cannot hold
   if (WORD_W < 1 || ADDR_W < 1) begin : g_chk
      $error("sei_word_mem needs positive widths");
   end

   // Write and registered read
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_ff[waddr_i] <= wdata_i;
      end
      if (re_i) begin
         rdata_o <= mem_ff[raddr_i];
      end
   end
endmodule
`default_nettype wire
